// File: src/tlb_pkg.sv
// Package: constants and types shared by the trigger layer logic
package tlb_pkg;
	// ----------------------------------------
	// Layers, lines and event sources
	// ----------------------------------------
	localparam int NUM_LAYERS = 3;
	localparam int NUM_LINES = 6;
	localparam int NUM_OUTS = 7; // Six link lines plus channel-ready
	localparam logic [1:0] L_ARM1 = 2'h0;
	localparam logic [1:0] L_ARM2 = 2'h1;
	localparam logic [1:0] L_TRIG = 2'h2;
	localparam logic [1:0] SRC_IMM = 2'h0;
	localparam logic [1:0] SRC_EXT = 2'h1;
	localparam logic [1:0] SRC_LINK = 2'h2;
	localparam logic [1:0] SRC_SOFT = 2'h3;
	localparam logic [2:0] LINE_MIN = 3'h1;
	localparam logic [2:0] LINE_MAX = 3'h6;
	localparam logic [6:0] READY_ONEHOT = 7'h40;
	// ----------------------------------------
	// Values after reset and preset
	// ----------------------------------------
	localparam logic [2:0] INPUT_LINE_SELECT_RST = 3'h1;
	localparam logic [2:0] BYP_RST = 3'h0; // All layers wait for event
	localparam logic [2:0] BYP_PRESET = 3'h4; // Trigger layer bypassed
	// ----------------------------------------
	// Output pulse timing
	// ----------------------------------------
	localparam int CLK_NS = 20;
	localparam int PULSE_NS = 10000;
	localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [3:0] {
		S_IDLE = 4'h1,
		S_WAIT = 4'h2,
		S_DELAY = 4'h4,
		S_ACT = 4'h8
	} tlb_state_t;
endpackage

// File: src/tlb_line_if.sv
// Interface: edges seen on and pulses fired onto the trigger lines
`timescale 1ns/1ps
interface tlb_line_if;
	logic [6:0] rise; // Bit 6 is the external input
	logic [6:0] fire; // Bit 6 is the channel-ready output
	modport io (output rise, input fire);
	modport seq (input rise, output fire);
endinterface

// File: src/tlb_line_io.sv
// Line input synchronisers and output pulse shapers
`timescale 1ns/1ps
module tlb_line_io #(
	parameter int PULSE_CYC = tlb_pkg::PULSE_CYC
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [5:0] link_in,
	input wire logic ext_in,
	tlb_line_if.io lines,
	output logic [5:0] link_out,
	output logic [5:0] link_oe,
	output logic ready_out
);
	localparam logic [15:0] PULSE_LOAD = 16'(PULSE_CYC - 1);
	wire [6:0] pin_w = {ext_in, link_in};
	logic [6:0] out_r;
	logic [6:0] rise_r;

	// ----------------------------------------
	// One channel per line
	// ----------------------------------------
	for (genvar i = 0; i < 7; i++) begin : g_ch
		logic s1_r, s2_r, s3_r, lvl_r;
		logic [15:0] cnt_r;
		wire settled_w = (s2_r == s3_r);
		// Three-stage sync; level moves once stages two and three agree
		always_ff @(posedge core_clk or posedge rst) begin
			if (rst) begin
				s1_r <= 1'b0;
				s2_r <= 1'b0;
				s3_r <= 1'b0;
				lvl_r <= 1'b0;
				rise_r[i] <= 1'b0;
			end else begin
				s1_r <= pin_w[i];
				s2_r <= s1_r;
				s3_r <= s2_r;
				lvl_r <= settled_w ? s3_r : lvl_r;
				rise_r[i] <= settled_w & s3_r & ~lvl_r;
			end
		end
		// Fixed-width pulse, restarted by a new request
		always_ff @(posedge core_clk or posedge rst) begin
			if (rst) begin
				cnt_r <= 16'h0000;
				out_r[i] <= 1'b0;
			end else begin
				cnt_r <= lines.fire[i] ? PULSE_LOAD : (cnt_r != 16'h0000 ? cnt_r - 16'h0001 : cnt_r);
				out_r[i] <= lines.fire[i] | (cnt_r != 16'h0000);
			end
		end
	end

	assign lines.rise = rise_r;
	assign link_out = out_r[5:0];
	assign link_oe = out_r[5:0]; // Driven only during a pulse
	assign ready_out = out_r[6];
endmodule

// File: src/tlb_seq.sv
// Trigger layer sequencer with source bypass and link line select
`timescale 1ns/1ps
module tlb_seq #(
	parameter int CNT_W = 8,
	parameter int PULSE_CYC = tlb_pkg::PULSE_CYC
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [2:0] soft_evt,
	input wire logic [2:0][1:0] link_event_source,
	input wire logic [2:0][CNT_W-1:0] count,
	input wire logic [2:0][2:0] output_line_select,
	input wire logic shared_line_protocol,
	input wire logic [2:0] byp_wr,
	input wire logic byp_val,
	input wire logic [2:0] ilin_wr,
	input wire logic [2:0] ilin_val,
	input wire logic sw_reset,
	input wire logic preset,
	input wire logic delay_done,
	input wire logic action_done,
	input wire logic [5:0] link_in,
	input wire logic ext_in,
	output logic [5:0] link_out,
	output logic [5:0] link_oe,
	output logic ready_out,
	output logic [2:0][2:0] input_line_select,
	output logic [2:0] bypass_on,
	output logic ilin_err,
	output logic delay_start,
	output logic action_req,
	output logic busy
);
	tlb_line_if lines();
	tlb_pkg::tlb_state_t st_r, st_nxt;
	logic [1:0] lay_r, lay_nxt;
	logic first_r, first_nxt;
	logic [2:0][CNT_W-1:0] cnt_r, cnt_nxt;
	logic [6:0] fire_r, fire_nxt;
	logic [2:0] byp_r;
	logic [2:0][2:0] ilin_r;
	logic err_r, dly_r, dly_nxt, act_r, busy_r, leave2;
	wire [2:0] evt_w, last_w, ok_w;
	wire [2:0][6:0] route_w;
	wire [1:0] src_w = link_event_source[lay_r];
	wire src_bypassable_w = (src_w == tlb_pkg::SRC_EXT) || (src_w == tlb_pkg::SRC_LINK);
	wire byp_eff = first_r & byp_r[lay_r] & src_bypassable_w;
	wire go = byp_eff | evt_w[lay_r];

	// ----------------------------------------
	// Line handling
	// ----------------------------------------
	tlb_line_io #(.PULSE_CYC(PULSE_CYC)) u_io (
		.core_clk(core_clk),
		.rst(rst),
		.link_in(link_in),
		.ext_in(ext_in),
		.lines(lines.io),
		.link_out(link_out),
		.link_oe(link_oe),
		.ready_out(ready_out)
	);

	// ----------------------------------------
	// Per-layer event, pass limit, routing
	// ----------------------------------------
	for (genvar l = 0; l < 3; l++) begin : g_lay
		wire [2:0] in_idx = ilin_r[l] - 3'h1;
		wire [2:0] use_line = (l == 2 && shared_line_protocol) ? ilin_r[l] :
			output_line_select[l];
		wire [2:0] out_idx = use_line - 3'h1;
		assign evt_w[l] = (link_event_source[l] == tlb_pkg::SRC_IMM) ? 1'b1 :
			(link_event_source[l] == tlb_pkg::SRC_EXT) ? lines.rise[6] :
			(link_event_source[l] == tlb_pkg::SRC_LINK) ? lines.rise[in_idx] :
			soft_evt[l];
		assign last_w[l] = ({1'b0, cnt_r[l]} + {{CNT_W{1'b0}}, 1'b1}) >= {1'b0, count[l]};
		assign route_w[l] = (link_event_source[l] == tlb_pkg::SRC_LINK) ?
			(7'h01 << out_idx) : tlb_pkg::READY_ONEHOT;
		assign ok_w[l] = (ilin_val >= tlb_pkg::LINE_MIN) && (ilin_val <= tlb_pkg::LINE_MAX) &&
			(ilin_val != output_line_select[l]);
	end

	// ----------------------------------------
	// Sequencer next state
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		lay_nxt = lay_r;
		first_nxt = first_r;
		cnt_nxt = cnt_r;
		fire_nxt = 7'h00;
		dly_nxt = 1'b0;
		leave2 = 1'b0;
		case (st_r)
			tlb_pkg::S_IDLE: begin
				if (start) begin
					st_nxt = tlb_pkg::S_WAIT;
					lay_nxt = tlb_pkg::L_ARM1;
					first_nxt = 1'b1;
					cnt_nxt = '0;
				end
			end
			tlb_pkg::S_WAIT: begin
				if (go && lay_r == tlb_pkg::L_ARM1) begin
					if (byp_r[0]) begin
						fire_nxt = route_w[0];
					end
					lay_nxt = tlb_pkg::L_ARM2;
					first_nxt = 1'b1;
					cnt_nxt[1] = '0;
				end else if (go && byp_eff) begin
					// Bypass also jumps over the delay
					if (lay_r == tlb_pkg::L_ARM2) begin
						leave2 = 1'b1;
					end else begin
						st_nxt = tlb_pkg::S_ACT;
					end
				end else if (go) begin
					st_nxt = tlb_pkg::S_DELAY;
					dly_nxt = 1'b1;
				end
			end
			tlb_pkg::S_DELAY: begin
				if (delay_done && lay_r == tlb_pkg::L_ARM2) begin
					leave2 = 1'b1;
				end else if (delay_done) begin
					st_nxt = tlb_pkg::S_ACT;
				end
			end
			tlb_pkg::S_ACT: begin
				if (action_done) begin
					fire_nxt = route_w[2];
					st_nxt = tlb_pkg::S_WAIT;
					first_nxt = 1'b0;
					if (!last_w[2]) begin
						cnt_nxt[2] = cnt_r[2] + {{(CNT_W-1){1'b0}}, 1'b1};
					end else if (!last_w[1]) begin
						cnt_nxt[1] = cnt_r[1] + {{(CNT_W-1){1'b0}}, 1'b1};
						lay_nxt = tlb_pkg::L_ARM2;
					end else if (!last_w[0]) begin
						cnt_nxt[0] = cnt_r[0] + {{(CNT_W-1){1'b0}}, 1'b1};
						lay_nxt = tlb_pkg::L_ARM1;
					end else begin
						st_nxt = tlb_pkg::S_IDLE;
					end
				end
			end
			default: begin
				st_nxt = tlb_pkg::S_IDLE;
			end
		endcase
		// Leaving arm layer 2 into the trigger layer
		if (leave2) begin
			if (byp_r[1]) begin
				fire_nxt = route_w[1];
			end
			lay_nxt = tlb_pkg::L_TRIG;
			st_nxt = tlb_pkg::S_WAIT;
			first_nxt = 1'b1;
			cnt_nxt[2] = '0;
		end
	end

	// ----------------------------------------
	// Sequencer registers
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_r <= tlb_pkg::S_IDLE;
			lay_r <= tlb_pkg::L_ARM1;
			first_r <= 1'b0;
			cnt_r <= '0;
			fire_r <= 7'h00;
			dly_r <= 1'b0;
			act_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			lay_r <= lay_nxt;
			first_r <= first_nxt;
			cnt_r <= cnt_nxt;
			fire_r <= fire_nxt;
			dly_r <= dly_nxt;
			act_r <= (st_nxt == tlb_pkg::S_ACT);
			busy_r <= (st_nxt != tlb_pkg::S_IDLE);
		end
	end
	assign lines.fire = fire_r;

	// ----------------------------------------
	// Bypass and input line settings
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			byp_r <= tlb_pkg::BYP_RST;
			ilin_r <= {3{tlb_pkg::INPUT_LINE_SELECT_RST}};
			err_r <= 1'b0;
		end else if (sw_reset || preset) begin
			byp_r <= sw_reset ? tlb_pkg::BYP_RST : tlb_pkg::BYP_PRESET;
			ilin_r <= {3{tlb_pkg::INPUT_LINE_SELECT_RST}};
			err_r <= 1'b0;
		end else begin
			for (int l = 0; l < 3; l++) begin
				if (byp_wr[l]) begin
					byp_r[l] <= byp_val;
				end
				if (ilin_wr[l] && ok_w[l]) begin
					ilin_r[l] <= ilin_val;
				end
			end
			err_r <= |(ilin_wr & ~ok_w);
		end
	end
	assign input_line_select = ilin_r;
	assign bypass_on = byp_r;
	assign ilin_err = err_r;
	assign delay_start = dly_r;
	assign action_req = act_r;
	assign busy = busy_r;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	property p_hold;
		st_r == tlb_pkg::S_WAIT && !go |=> st_r == tlb_pkg::S_WAIT && lay_r == $past(lay_r);
	endproperty
	a_hold: assert property (p_hold) else $error("layer moved without event");
	property p_preset;
		preset && !sw_reset |=> byp_r == tlb_pkg::BYP_PRESET &&
			ilin_r == {3{tlb_pkg::INPUT_LINE_SELECT_RST}};
	endproperty
	a_preset: assert property (p_preset) else $error("preset bypass wrong");
	property p_greset;
		sw_reset |=> byp_r == tlb_pkg::BYP_RST && ilin_r == {3{tlb_pkg::INPUT_LINE_SELECT_RST}} && !err_r;
	endproperty
	a_greset: assert property (p_greset) else $error("reset bypass wrong");
	property p_skip;
		st_r == tlb_pkg::S_WAIT && byp_eff |=> st_r != tlb_pkg::S_DELAY && !dly_r;
	endproperty
	a_skip: assert property (p_skip) else $error("bypass did not skip");
	property p_first;
		st_r == tlb_pkg::S_WAIT && first_r && byp_r[lay_r] && src_bypassable_w
			|=> st_r != tlb_pkg::S_WAIT || lay_r != $past(lay_r);
	endproperty
	a_first: assert property (p_first) else $error("first pass waited");
	property p_repeat;
		$past(st_r) == tlb_pkg::S_ACT && st_r == tlb_pkg::S_WAIT |-> !first_r;
	endproperty
	a_repeat: assert property (p_repeat) else $error("repeat pass bypassed");
	property p_armfire;
		st_r == tlb_pkg::S_WAIT && lay_r == tlb_pkg::L_ARM1 && go
			|=> (|fire_r) == $past(byp_r[0]);
	endproperty
	a_armfire: assert property (p_armfire) else $error("arm1 pulse wrong");
	property p_trigfire;
		st_r == tlb_pkg::S_ACT && action_done |=> $countones(fire_r) == 1 ##1 !act_r || busy_r;
	endproperty
	a_trigfire: assert property (p_trigfire) else $error("no trigger pulse");
	property p_reject;
		!sw_reset && !preset && ilin_wr[0] && ilin_val == output_line_select[0]
			|=> err_r && ilin_r[0] == $past(ilin_r[0]);
	endproperty
	a_reject: assert property (p_reject) else $error("clash not rejected");
	property p_range;
		ilin_r[0] inside {[tlb_pkg::LINE_MIN:tlb_pkg::LINE_MAX]} &&
			ilin_r[1] inside {[tlb_pkg::LINE_MIN:tlb_pkg::LINE_MAX]} &&
			ilin_r[2] inside {[tlb_pkg::LINE_MIN:tlb_pkg::LINE_MAX]};
	endproperty
	a_range: assert property (p_range) else $error("input line out of range");
endmodule

// File: bench/tlb_link_partner.sv
// Far-side model: instruments on the trigger link and external input
`timescale 1ns/1ps
module tlb_link_partner #(
	parameter int PULSE_CYC = 4
) (
	input wire logic core_clk,
	input wire logic send,
	input wire logic clr,
	input wire logic [2:0] send_line,
	input wire logic [5:0] link_out,
	input wire logic [5:0] link_oe,
	input wire logic ready_out,
	output logic [5:0] link_in,
	output logic ext_in
);
	logic [6:0] drv = 7'h00;
	logic [6:0] seen;
	int hold = 0;
	int n_bad = 0;
	int n_pulse [7];
	int run [7];
	// Lines are wired OR with pull-downs, so device pulses reach every listener
	assign seen = {ready_out, link_out & link_oe};
	assign link_in = drv[5:0] | seen[5:0];
	assign ext_in = drv[6];
	// Raise one line for a few cycles on request, then release it low
	always @(posedge core_clk) begin
		hold <= send ? 8 : (hold > 0 ? hold - 1 : 0);
		drv <= #1 send ? 7'h01 << send_line : (hold > 1 ? drv : 7'h00);
	end
	// Count pulses per line and flag any of the wrong width; clr restarts the counts
	always @(posedge core_clk) begin
		for (int i = 0; i < 7; i++) begin
			if (seen[i] === 1'b1) begin
				run[i] = run[i] + 1;
			end else if (run[i] != 0) begin
				n_pulse[i] = n_pulse[i] + 1;
				n_bad = n_bad + ((run[i] != PULSE_CYC) ? 1 : 0);
				run[i] = 0;
			end
			if (clr) begin
				n_pulse[i] = 0;
			end
		end
	end
endmodule

// File: bench/test_tlb_seq.sv
// Testbench for the trigger layer sequencer
`timescale 1ns/1ps
module test_tlb_seq;
	localparam int PC = 4;
	logic core_clk = 0, rst = 1, start = 0, shared_line_protocol = 0, send = 0, clr = 0;
	logic byp_val = 0, sw_reset = 0, preset = 0, delay_done = 1, action_done = 0;
	logic ext_in, ilin_err, ready_out, delay_start, action_req, busy;
	logic [2:0] soft_evt = 3'h0, byp_wr = 3'h0, ilin_wr = 3'h0, ilin_val = 3'h1;
	logic [2:0] send_line = 3'h0, bypass_on;
	logic [2:0][1:0] src = 6'h00;
	logic [2:0][7:0] count = 24'h01_0101;
	logic [2:0][2:0] osel = 9'h12a, input_line_select;
	logic [5:0] link_in, link_out, link_oe;
	int error_cnt = 0, num_checks = 0, n_dly = 0, act_cyc = 0, cyc = 0;

	tlb_seq #(.CNT_W(8), .PULSE_CYC(PC)) i_dut (
		.core_clk(core_clk), .rst(rst), .start(start), .soft_evt(soft_evt),
		.link_event_source(src), .count(count), .output_line_select(osel),
		.shared_line_protocol(shared_line_protocol), .byp_wr(byp_wr), .byp_val(byp_val),
		.ilin_wr(ilin_wr), .ilin_val(ilin_val), .sw_reset(sw_reset), .preset(preset),
		.delay_done(delay_done), .action_done(action_done), .link_in(link_in),
		.ext_in(ext_in), .link_out(link_out), .link_oe(link_oe), .ready_out(ready_out),
		.input_line_select(input_line_select), .bypass_on(bypass_on), .ilin_err(ilin_err),
		.delay_start(delay_start), .action_req(action_req), .busy(busy));
	tlb_link_partner #(.PULSE_CYC(PC)) i_lp (
		.core_clk(core_clk), .send(send), .send_line(send_line), .link_out(link_out),
		.link_oe(link_oe), .ready_out(ready_out), .link_in(link_in), .ext_in(ext_in),
		.clr(clr));

	// Clock
	initial forever #10 core_clk = ~core_clk;
	// Device action answers after six cycles; delays counted; hang guard
	always @(posedge core_clk) begin
		#1;
		if (delay_start === 1'b1) n_dly++;
		act_cyc = (action_req === 1'b1) ? act_cyc + 1 : 0;
		action_done = (act_cyc >= 6);
		cyc++;
		if (cyc > 2000) begin
			error_cnt++;
			finish_test();
		end
	end

	// ----------------
	// Access tasks
	// ----------------
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr_ilin(input int l, input logic [2:0] v, input logic e);
		ilin_val = v;
		ilin_wr = 3'h1 << l;
		step(1);
		chk(16'(ilin_err), 16'(e));
		ilin_wr = 3'h0;
		step(1);
	endtask
	task automatic wr_byp(input logic [2:0] m, input logic v);
		byp_val = v;
		byp_wr = m;
		step(1);
		byp_wr = 3'h0;
		step(1);
	endtask
	task automatic event_on(input logic [2:0] b);
		send_line = b;
		send = 1;
		step(1);
		send = 0;
	endtask
	task automatic go();
		n_dly = 0;
		clr = 1;
		start = 1;
		step(1);
		start = 0;
		clr = 0;
	endtask
	task automatic fin(input int dly, input int rdy, input int li, input int lc);
		int tot;
		tot = 0;
		for (int i = 0; i < 200 && busy !== 1'b0; i++) step(1);
		step(PC + 4);
		for (int k = 0; k < 6; k++) tot += i_lp.n_pulse[k];
		chk(16'(busy), 16'h0000);
		chk(16'(n_dly), 16'(dly));
		chk(16'(i_lp.n_pulse[6]), 16'(rdy));
		chk(16'(i_lp.n_pulse[li]), 16'(lc));
		chk(16'(tot), 16'(lc));
		chk(16'(i_lp.n_bad), 16'h0000);
		$display("sequence test done at %0t", $time);
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ----------------
	// Test sequence
	// ----------------
	initial begin
		step(3);
		rst = 0;
		chk(16'(input_line_select), 16'h0049);
		chk(16'(bypass_on), 16'h0000);
		preset = 1;
		step(1);
		preset = 0;
		chk(16'(bypass_on), 16'h0004);
		wr_byp(3'h3, 1'b1);
		sw_reset = 1;
		step(1);
		sw_reset = 0;
		chk(16'(bypass_on), 16'h0000);
		$display("settings test done");
		wr_ilin(2, 3'h3, 1'b0);
		wr_ilin(2, 3'h4, 1'b1);
		wr_ilin(2, 3'h7, 1'b1);
		wr_ilin(1, 3'h5, 1'b1);
		wr_ilin(0, 3'h2, 1'b1);
		wr_ilin(0, 3'h6, 1'b0);
		chk(16'(input_line_select), 16'h00ce);
		$display("line select test done");
		go();
		fin(2, 1, 0, 0);
		src[0] = tlb_pkg::SRC_EXT;
		go();
		step(30);
		chk(16'(busy), 16'h0001);
		chk(16'(n_dly), 16'h0000);
		event_on(3'h6);
		fin(2, 1, 0, 0);
		wr_byp(3'h3, 1'b1);
		src = {tlb_pkg::SRC_IMM, tlb_pkg::SRC_EXT, tlb_pkg::SRC_LINK};
		count[0] = 8'h02;
		go();
		step(40);
		chk(16'(busy), 16'h0001);
		chk(16'(i_lp.n_pulse[1]), 16'h0001);
		event_on(3'h5);
		fin(2, 4, 1, 2);
		wr_byp(3'h3, 1'b0);
		wr_byp(3'h4, 1'b1);
		src = {tlb_pkg::SRC_LINK, tlb_pkg::SRC_SOFT, tlb_pkg::SRC_IMM};
		soft_evt = 3'h2;
		shared_line_protocol = 1;
		count[0] = 8'h01;
		go();
		fin(1, 0, 2, 1);
		finish_test();
	end
endmodule
